//--- testbench/emzd_host_model.sv
// Host model: a single AHB-Lite master making single word transfers.
// Assumes one slave whose hreadyout is the bus hready, always OKAY.
module emzd_host_model (
  // Clock and bus answer
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  // Bus request
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero, word size only
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h00000000;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'b010;
    hwdata_o = 32'h00000000;
  end

  // Address phase held until accepted; released address is inverted, not left stale
  task automatic addr_phase(input logic [7:0] idx, input logic wr);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= {22'h000000, idx, 2'b00};
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'b00;
    haddr_o <= ~{22'h000000, idx, 2'b00};
  endtask

  // Write: data held until the data phase is accepted
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    addr_phase(idx, 1'b1);
    hwdata_o <= {24'h000000, d};
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hwdata_o <= ~{24'h000000, d};
  endtask

  // Read: data taken at the edge that ends the data phase
  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    addr_phase(idx, 1'b0);
    do @(posedge clk_i); while (hready_i !== 1'b1);
    d = hrdata_i;
  endtask
endmodule // emzd_host_model

//--- testbench/emzd_properties.sv
// Checker for the zone decode block, watching top-level ports only.
// Assumes one clk_sys_i domain with an active-low reset.
module emzd_properties (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic mem_valid_i,
  input wire logic zone_hit_o,
  input wire logic zone_one_o,
  input wire logic ext_bus_irq_input_i,
  input wire logic [15:0] host_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // Routing never drives line zero and drives at most one line
  irq_line_zero_a: assert property (host_irq_o[0] == 1'b0) else $error("host line 0 raised");
  irq_one_line_a: assert property ($onehot0(host_irq_o)) else $error("several host lines");
  // A quiet pin leaves every line low; a line rises only on a pin high three edges back
  irq_quiet_pin_a: assert property ((!ext_bus_irq_input_i)[*4] |=> host_irq_o == 16'h0000)
    else $error("line high with quiet pin");
  irq_rise_cause_a: assert property ($rose(host_irq_o != 16'h0000) |-> $past(ext_bus_irq_input_i, 3))
    else $error("line rose without pin");
  // A hit answers a valid cycle one edge earlier
  hit_cause_a: assert property (zone_hit_o |-> $past(mem_valid_i)) else $error("hit without cycle");
  zone_one_hit_a: assert property (zone_one_o |-> zone_hit_o) else $error("zone one without hit");
  // Refused writes still end as ready and OKAY
  bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or okay");
  // Outputs start quiet after reset
  reset_quiet_a: assert property ($rose(rst_n_i) |-> !zone_hit_o && host_irq_o == 16'h0000)
    else $error("outputs busy after reset");

  hit_seen_c: cover property (zone_hit_o && !zone_one_o);
  one_seen_c: cover property (zone_one_o);
  irq_seen_c: cover property ($rose(host_irq_o != 16'h0000));
endmodule // emzd_properties

bind emzd_top emzd_properties u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .mem_valid_i(mem_valid_i), .zone_hit_o(zone_hit_o), .zone_one_o(zone_one_o),
  .ext_bus_irq_input_i(ext_bus_irq_input_i), .host_irq_o(host_irq_o));

//--- testbench/tb_top.sv
// Self-checking bench for the zone decode block: registers, decode, routing.
// Assumes the host model speaks the register bus; the bench drives the rest.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, rst_n_i, hsel, hwrite, hreadyout, hresp, mem_valid, zone_hit, zone_one, irq_pin;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, mem_addr;
  logic [15:0] host_irq;
  int n_fail = 0;
  int check_count = 0;

  emzd_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .mem_valid_i(mem_valid), .mem_addr_i(mem_addr),
    .zone_hit_o(zone_hit), .zone_one_o(zone_one), .ext_bus_irq_input_i(irq_pin), .host_irq_o(host_irq));
  emzd_host_model host (.clk_i(clk_sys_i), .hready_i(hreadyout), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

  // Verdict and comparisons
  task automatic end_sim();
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h00000000, got}, {31'h00000000, exp});
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    host.rd(idx, v);
    chk_word(v, exp);
  endtask

  // One memory cycle; the answer stands in the following cycle only
  task automatic probe(input logic [31:0] a, input logic hit, input logic one);
    @(posedge clk_sys_i);
    mem_valid <= 1'b1;
    mem_addr <= a;
    @(posedge clk_sys_i);
    mem_valid <= 1'b0;
    #1;
    chk_flag(zone_hit, hit);
    chk_flag(zone_one, one);
  endtask

  // Reset values, then an unmapped word that must read zero
  task automatic t_reset();
    for (int i = 'hf9; i <= 'hfc; i++) begin
      rd_chk(8'(i), 32'h00000000);
    end
    host.wr(8'h10, 8'h5a);
    rd_chk(8'h10, 32'h00000000);
  endtask

  // Window edges for one size code; bases given are aligned to the window
  task automatic t_zone(input logic [7:0] bh, input logic [7:0] bl, input logic [3:0] code);
    logic [31:0] base, span;
    logic ok;
    base = {bh, bl, 16'h0000};
    span = 32'h00000001 << (code + 16);
    ok = code <= 4'h8;
    host.wr(emzd_pkg::IDX_BASE_HIGH, bh);
    host.wr(emzd_pkg::IDX_BASE_LOW, bl);
    host.wr(emzd_pkg::IDX_ZONE_SIZE, {4'h0, code});
    rd_chk(emzd_pkg::IDX_ZONE_SIZE, {28'h0000000, code});
    rd_chk(emzd_pkg::IDX_STATUS, ok ? 32'h00000000 : 32'h00000010);
    probe(base, ok, 1'b0);
    probe(base + span - 32'h1, ok, 1'b0);
    probe(base + span, 1'b0, 1'b0);
    probe(base - 32'h1, 1'b0, 1'b0);
  endtask

  // Second zone sits right above the first and has the same size
  task automatic t_dual();
    host.wr(emzd_pkg::IDX_BASE_HIGH, 8'h40);
    host.wr(emzd_pkg::IDX_BASE_LOW, 8'h02);
    host.wr(emzd_pkg::IDX_ZONE_SIZE, 8'h01);
    host.wr(emzd_pkg::IDX_CTRL, 8'h10);
    host.wr(emzd_pkg::IDX_HIT_COUNT, 8'h00);
    probe(32'h40020000, 1'b1, 1'b0);
    probe(32'h40040000, 1'b1, 1'b1);
    probe(32'h4005ffff, 1'b1, 1'b1);
    probe(32'h40060000, 1'b0, 1'b0);
    rd_chk(emzd_pkg::IDX_HIT_COUNT, 32'h00000003);
    host.wr(emzd_pkg::IDX_CTRL, 8'h00);
  endtask

  // Locked registers keep their value until unlocked
  task automatic t_lock();
    host.wr(emzd_pkg::IDX_CTRL, 8'h80);
    host.wr(emzd_pkg::IDX_BASE_HIGH, 8'haa);
    host.wr(emzd_pkg::IDX_ZONE_SIZE, 8'h05);
    rd_chk(emzd_pkg::IDX_BASE_HIGH, 32'h00000040);
    rd_chk(emzd_pkg::IDX_ZONE_SIZE, 32'h00000001);
    rd_chk(emzd_pkg::IDX_CTRL, 32'h00000080);
    rd_chk(emzd_pkg::IDX_STATUS, 32'h00000008);
    host.wr(emzd_pkg::IDX_UNLOCK, 8'h01);
    host.wr(emzd_pkg::IDX_BASE_HIGH, 8'haa);
    rd_chk(emzd_pkg::IDX_BASE_HIGH, 32'h000000aa);
  endtask

  // Every map code with the pin high, then the pin dropped
  task automatic t_irq();
    irq_pin <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      host.wr(emzd_pkg::IDX_IRQ_ROUTE, 8'(c));
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk_word({16'h0000, host_irq}, (c == 0) ? 32'h0 : (32'h1 << c));
    end
    rd_chk(emzd_pkg::IDX_STATUS, 32'h00000004);
    irq_pin <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk_word({16'h0000, host_irq}, 32'h00000000);
  endtask

  // Free-running clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    end_sim();
  end

  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    mem_valid = 1'b0;
    mem_addr = 32'h00000000;
    irq_pin = 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_zone(8'h12, 8'h34, 4'h0);
    t_zone(8'h12, 8'h36, 4'h1);
    t_zone(8'h12, 8'h00, 4'h8);
    t_zone(8'h12, 8'h00, 4'h9);
    t_dual();
    t_lock();
    t_irq();
    end_sim();
  end
endmodule // tb_top

//--- verilog/emzd_cfg_if.sv
// Configuration carrier from the register bank to the decode and routing units.
// Assumes one clock domain; all fields are registered by the bank.
interface emzd_cfg_if;
  logic [7:0] base_high;
  logic [7:0] base_low;
  logic [3:0] size_code;
  logic dual_en;
  logic [3:0] route;

  modport src (output base_high, output base_low, output size_code, output dual_en, output route);
  modport dst (input base_high, input base_low, input size_code, input dual_en, input route);
endinterface

//--- verilog/emzd_irq_route.sv
// Routes the expansion-bus interrupt pin onto one of the host lines 1 to 15.
// Assumes the pin is asynchronous to clk_sys_i.
module emzd_irq_route (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Configuration
  emzd_cfg_if.dst cfg,
  // Interrupt pin and host lines
  input wire logic ext_bus_irq_input_i,
  output logic ext_irq_sync_o,
  output logic [15:0] host_irq_o
);
  logic meta_reg;
  logic sync_reg;
  logic [15:0] line_reg;

  // Two-flop synchroniser for the pin
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= ext_bus_irq_input_i;
      sync_reg <= meta_reg;
    end
  end

  // One flop per line; line 0 stays low because code zero means routing is off
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_line
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          line_reg[gi] <= 1'b0;
        end else begin
          line_reg[gi] <= (gi != 0) && sync_reg && (cfg.route == 4'(gi));
        end
      end
    end
  endgenerate

  assign ext_irq_sync_o = sync_reg;
  assign host_irq_o = line_reg;
endmodule // emzd_irq_route

//--- verilog/emzd_pkg.sv
// Package for the expansion memory zone decode block: register indices,
// field positions, reset values and the zone decode helpers.
// Assumes a 32-bit memory address space and registers reached over AHB-Lite.
package emzd_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'hf8;
  localparam logic [7:0] IDX_BASE_HIGH = 8'hf9;
  localparam logic [7:0] IDX_BASE_LOW = 8'hfa;
  localparam logic [7:0] IDX_ZONE_SIZE = 8'hfb;
  localparam logic [7:0] IDX_IRQ_ROUTE = 8'hfc;
  localparam logic [7:0] IDX_UNLOCK = 8'hfd;
  localparam logic [7:0] IDX_STATUS = 8'hfe;
  localparam logic [7:0] IDX_HIT_COUNT = 8'hff;

  // Field positions
  localparam int CTRL_LOCK_BIT = 7;
  localparam int CTRL_DUAL_BIT = 4;
  localparam int UNLOCK_BIT = 0;
  localparam int STAT_HIT_BIT = 0;
  localparam int STAT_ZONE_ONE_BIT = 1;
  localparam int STAT_IRQ_BIT = 2;
  localparam int STAT_LOCK_BIT = 3;
  localparam int STAT_SIZE_RSVD_BIT = 4;
  localparam int BASE_HIGH_LSB = 24;
  localparam int BASE_LOW_LSB = 16;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_CODE = 4'h0;

  // Zone size is two to the power of (code plus this offset)
  localparam logic [5:0] SIZE_EXP_OFFSET = 6'h10;
  localparam logic [3:0] SIZE_CODE_MAX = 4'h8;

  // Mask keeping the address bits above the window
  function automatic logic [31:0] zone_mask(input logic [3:0] code);
    logic [5:0] n;
    n = {2'h0, code} + SIZE_EXP_OFFSET;
    return 32'hffffffff << n;
  endfunction

  // Window size in bytes
  function automatic logic [31:0] zone_span(input logic [3:0] code);
    logic [5:0] n;
    n = {2'h0, code} + SIZE_EXP_OFFSET;
    return 32'h00000001 << n;
  endfunction

  // Address lies in the window starting at base
  function automatic logic zone_match(input logic [31:0] addr, input logic [31:0] base,
                                      input logic [3:0] code);
    return (addr & zone_mask(code)) == (base & zone_mask(code));
  endfunction

endpackage

//--- verilog/emzd_top.sv
// Expansion memory zone decode: AHB-Lite register bank, zone decode and
// expansion interrupt routing.
// Assumes a single AHB-Lite master, word accesses and a 100 MHz clk_sys_i.
//
// Overview of operation
// - High base byte is address bits 31-24
// - Low base byte is bits 23-16; rest zero
// - Zone size is two to code plus sixteen
// - Map code routes interrupt to IRQ1-15, zero off
// - Base and size registers reset to zero
// - Lock makes base and size read-only
// - Dual mode adds equal zone above first
module emzd_top #(
  parameter int HIT_CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Memory cycles to decode
  input wire logic mem_valid_i,
  input wire logic [31:0] mem_addr_i,
  output logic zone_hit_o,
  output logic zone_one_o,
  // Interrupt routing
  input wire logic ext_bus_irq_input_i,
  output logic [15:0] host_irq_o
);

  // Elaboration check on the counter width
  generate
    if (HIT_CNT_W < 1 || HIT_CNT_W > 32) begin : g_bad_width
      $error("HIT_CNT_W must lie between 1 and 32");
    end
  endgenerate

  // Index match, used by every register decode
  function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] want);
    return idx == want;
  endfunction

  emzd_cfg_if cfg ();

  // Register state
  logic [7:0] zone_base_high_reg;
  logic [7:0] zone_base_high_next;
  logic [7:0] zone_base_low_reg;
  logic [7:0] zone_base_low_next;
  logic [3:0] zone_size_reg;
  logic [3:0] zone_size_next;
  logic [3:0] ext_irq_route_reg;
  logic [3:0] ext_irq_route_next;
  logic memory_map_lock_reg;
  logic memory_map_lock_next;
  logic dual_user_zone_enable_reg;
  logic dual_user_zone_enable_next;
  logic [HIT_CNT_W-1:0] hit_count_reg;
  logic [HIT_CNT_W-1:0] hit_count_next;

  // Bus state
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic hreadyout_reg;
  logic hresp_reg;

  // Status from the units
  logic zone_hit_w;
  logic zone_one_w;
  logic ext_irq_sync_w;

  // Address phase decode: one aligned word per register, above the map reads zero
  logic addr_ok;
  logic addr_phase;
  logic [7:0] addr_idx;
  assign addr_ok = (haddr_i[31:10] == 22'h000000) && (haddr_i[1:0] == 2'h0);
  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign addr_idx = addr_ok ? haddr_i[9:2] : 8'h00;

  // Data phase write strobes; the lock gates the zone registers and itself
  logic wr_any;
  logic wr_ctrl;
  logic wr_high;
  logic wr_low;
  logic wr_size;
  logic wr_route;
  logic wr_unlock;
  logic wr_count;
  logic [7:0] wdata;
  assign wr_any = wr_pend_reg;
  assign wdata = hwdata_i[7:0];
  assign wr_ctrl = wr_any && idx_is(wr_idx_reg, emzd_pkg::IDX_CTRL) && !memory_map_lock_reg;
  assign wr_high = wr_any && idx_is(wr_idx_reg, emzd_pkg::IDX_BASE_HIGH) && !memory_map_lock_reg;
  assign wr_low = wr_any && idx_is(wr_idx_reg, emzd_pkg::IDX_BASE_LOW) && !memory_map_lock_reg;
  assign wr_size = wr_any && idx_is(wr_idx_reg, emzd_pkg::IDX_ZONE_SIZE) && !memory_map_lock_reg;
  assign wr_route = wr_any && idx_is(wr_idx_reg, emzd_pkg::IDX_IRQ_ROUTE);
  assign wr_unlock = wr_any && idx_is(wr_idx_reg, emzd_pkg::IDX_UNLOCK) && wdata[emzd_pkg::UNLOCK_BIT];
  assign wr_count = wr_any && idx_is(wr_idx_reg, emzd_pkg::IDX_HIT_COUNT);

  // Next values of the configuration registers
  assign zone_base_high_next = wr_high ? wdata : zone_base_high_reg;
  assign zone_base_low_next = wr_low ? wdata : zone_base_low_reg;
  assign zone_size_next = wr_size ? wdata[3:0] : zone_size_reg;
  assign ext_irq_route_next = wr_route ? wdata[3:0] : ext_irq_route_reg;
  assign dual_user_zone_enable_next = wr_ctrl ? wdata[emzd_pkg::CTRL_DUAL_BIT] : dual_user_zone_enable_reg;

  // Unlock wins over a lock write in the same cycle; once set only unlock or reset clears
  assign memory_map_lock_next = wr_unlock ? 1'b0 :
                                wr_ctrl ? wdata[emzd_pkg::CTRL_LOCK_BIT] :
                                memory_map_lock_reg;

  // Hit counter: a hit in the clearing cycle is still counted
  assign hit_count_next = wr_count ? HIT_CNT_W'(zone_hit_w) :
                          hit_count_reg + HIT_CNT_W'(zone_hit_w);

  // Status word shows live decode and pin state
  logic [7:0] status_w;
  assign status_w = {3'h0,
                     zone_size_reg > emzd_pkg::SIZE_CODE_MAX,
                     memory_map_lock_reg,
                     ext_irq_sync_w,
                     zone_one_w,
                     zone_hit_w};

  // Read mux uses the next values so a read right after a write sees the new data
  logic [31:0] rd_ctrl;
  logic [31:0] rd_count;
  assign rd_ctrl = {24'h000000, memory_map_lock_next, 2'h0, dual_user_zone_enable_next, 4'h0};
  assign rd_count = 32'(hit_count_next);
  assign hrdata_next =
    idx_is(addr_idx, emzd_pkg::IDX_CTRL) ? rd_ctrl :
    idx_is(addr_idx, emzd_pkg::IDX_BASE_HIGH) ? {24'h000000, zone_base_high_next} :
    idx_is(addr_idx, emzd_pkg::IDX_BASE_LOW) ? {24'h000000, zone_base_low_next} :
    idx_is(addr_idx, emzd_pkg::IDX_ZONE_SIZE) ? {28'h0000000, zone_size_next} :
    idx_is(addr_idx, emzd_pkg::IDX_IRQ_ROUTE) ? {28'h0000000, ext_irq_route_next} :
    idx_is(addr_idx, emzd_pkg::IDX_STATUS) ? {24'h000000, status_w} :
    idx_is(addr_idx, emzd_pkg::IDX_HIT_COUNT) ? rd_count :
    32'h00000000;

  // Bus pipeline: zero wait states, always OKAY
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite_i && addr_ok;
      wr_idx_reg <= addr_idx;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      if (addr_phase && !hwrite_i) begin
        hrdata_reg <= hrdata_next;
      end
    end
  end

  // Zone registers clear on reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zone_base_high_reg <= emzd_pkg::RST_BYTE;
      zone_base_low_reg <= emzd_pkg::RST_BYTE;
      zone_size_reg <= emzd_pkg::RST_CODE;
      ext_irq_route_reg <= emzd_pkg::RST_CODE;
      memory_map_lock_reg <= 1'b0;
      dual_user_zone_enable_reg <= 1'b0;
    end else begin
      zone_base_high_reg <= zone_base_high_next;
      zone_base_low_reg <= zone_base_low_next;
      zone_size_reg <= zone_size_next;
      ext_irq_route_reg <= ext_irq_route_next;
      memory_map_lock_reg <= memory_map_lock_next;
      dual_user_zone_enable_reg <= dual_user_zone_enable_next;
    end
  end

  // Hit counter
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_count_reg <= '0;
    end else begin
      hit_count_reg <= hit_count_next;
    end
  end

  // Configuration to the units
  assign cfg.base_high = zone_base_high_reg;
  assign cfg.base_low = zone_base_low_reg;
  assign cfg.size_code = zone_size_reg;
  assign cfg.dual_en = dual_user_zone_enable_reg;
  assign cfg.route = ext_irq_route_reg;

  // Decode and routing units; misaligned bases are not corrected, the mask simply ignores low bits
  emzd_zone_match u_zone (
    .clk_sys_i (clk_sys_i),
    .rst_n_i (rst_n_i),
    .cfg (cfg.dst),
    .mem_valid_i (mem_valid_i),
    .mem_addr_i (mem_addr_i),
    .zone_hit_o (zone_hit_w),
    .zone_one_o (zone_one_w)
  );

  emzd_irq_route u_irq (
    .clk_sys_i (clk_sys_i),
    .rst_n_i (rst_n_i),
    .cfg (cfg.dst),
    .ext_bus_irq_input_i (ext_bus_irq_input_i),
    .ext_irq_sync_o (ext_irq_sync_w),
    .host_irq_o (host_irq_o)
  );

  // Outputs straight from flops
  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = hresp_reg;
  assign zone_hit_o = zone_hit_w;
  assign zone_one_o = zone_one_w;

endmodule // emzd_top

//--- verilog/emzd_zone_match.sv
// Memory zone decode: flags cycles that fall into zone 0 or zone 1.
// Assumes mem_addr_i and mem_valid_i come from logic on clk_sys_i.
module emzd_zone_match (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Configuration
  emzd_cfg_if.dst cfg,
  // Memory cycle
  input wire logic mem_valid_i,
  input wire logic [31:0] mem_addr_i,
  // Decode result
  output logic zone_hit_o,
  output logic zone_one_o
);
  logic [31:0] base0;
  logic [31:0] base1;
  logic size_ok;
  logic hit0;
  logic hit1;
  logic zone_hit_reg;
  logic zone_one_reg;

  // Base from the two bytes, low 16 bits zero
  assign base0 = {cfg.base_high, cfg.base_low, 16'h0000};
  // Second zone sits right above the first
  assign base1 = base0 + emzd_pkg::zone_span(cfg.size_code);
  // Reserved size codes decode nothing rather than a guessed window
  assign size_ok = cfg.size_code <= emzd_pkg::SIZE_CODE_MAX;
  assign hit0 = size_ok && emzd_pkg::zone_match(mem_addr_i, base0, cfg.size_code);
  assign hit1 = size_ok && cfg.dual_en && emzd_pkg::zone_match(mem_addr_i, base1, cfg.size_code);

  // Result registered one cycle after the cycle is offered
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zone_hit_reg <= 1'b0;
      zone_one_reg <= 1'b0;
    end else begin
      zone_hit_reg <= mem_valid_i && (hit0 || hit1);
      zone_one_reg <= mem_valid_i && !hit0 && hit1;
    end
  end

  assign zone_hit_o = zone_hit_reg;
  assign zone_one_o = zone_one_reg;
endmodule // emzd_zone_match
